/* dv/flsr_flash_model.sv */
/*
 * behavioural flash status model: status bytes, toggle bits and ready pin
 * during program, erase and erase suspend.
 * assumes the bench arms a mode before each poll; the address is not decoded.
 */
module flsr_flash_model #(
	parameter int ADDR_W = 22
) (
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        dq_out,
	input  wire logic              dq_oe,
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	input  wire logic              load,
	input  wire logic [1:0]        kind,
	input  wire logic              tmo,
	input  wire logic [7:0]        busy_reads,
	input  wire logic [7:0]        arr_data,
	input  wire logic [7:0]        pdata,
	output logic [7:0]             dq_in,
	output logic                   rb_low,
	output logic [7:0]             rst_cnt,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [7:0]             wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	import flsr_pkg::*;
	// ****************************************
	// status byte
	// ****************************************
	logic [7:0]        left_r = 8'h00;
	logic [7:0]        tog_r  = 8'h00;
	logic [7:0]        last_r = 8'h5a;
	logic [ADDR_W-1:0] cap_addr;
	logic [7:0]        cap_data;
	// read and write strobes, either select may end a read
	wire rd_act = !ce_n && !oe_n && we_n;
	wire wr_act = !ce_n && !we_n;
	wire busy_w = (kind != 2'd2) && (left_r != 8'h00);
	// encodings per mode
	wire [7:0] s_prog = {~pdata[7], tog_r[0], tmo, 5'h00};
	wire [7:0] s_ers = {1'b0, tog_r[0], tmo, 1'b0, 1'b1, tog_r[0], 2'h0};
	wire [7:0] s_sus = {1'b1, 1'b0, 1'b0, 2'h0, tog_r[0], 2'h0};
	wire [7:0] s_sel = (kind == 2'd2) ? s_sus : ((kind == 2'd1) ? s_ers : s_prog);
	// programming only clears bits, so the finished byte is old data and written data
	wire [7:0] arr_byte = (kind == 2'd0) ? (arr_data & pdata) : arr_data;
	wire [7:0] rbyte = (busy_w || kind == 2'd2) ? s_sel : arr_byte;
	// released bus never shows the last value
	assign dq_in = rd_act ? rbyte : ~last_r;
	assign rb_low = busy_w;
	initial rst_cnt = 8'h00;
	// new operation armed by the bench
	always @(posedge load) begin
		left_r = busy_reads;
		tog_r = 8'h00;
	end
	// each finished read is one toggle step
	always @(negedge rd_act) begin
		last_r = rbyte;
		tog_r = tog_r + 8'h01;
		if (left_r != 8'h00) begin
			left_r = left_r - 8'h01;
		end
	end
	// write data held while the host drives the bus
	always @* begin
		if (wr_act && dq_oe) begin
			cap_addr = addr;
			cap_data = dq_out;
		end
	end
	// reset command returns to array reads except in suspend mode; in erase mode it is ignored unless tmo is set
	always @(negedge wr_act) begin
		wr_addr = cap_addr;
		wr_data = cap_data;
		if (cap_data == RST_CMD && (kind != 2'd1 || tmo)) begin
			left_r = 8'h00;
			rst_cnt = rst_cnt + 8'h01;
		end
	end
endmodule // flsr_flash_model

/* dv/flsr_host_tb_top.sv */
/*
 * bench for the flash status poller: drives the software port, queues
 * expected read words and checks them from a watcher process.
 * assumes flsr_flash_model on the pins and a pull-up on the ready pin.
 */
module flsr_host_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import flsr_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic        reset, ref_clk, sw_wr, sw_rd, load, tmo, rd_pend;
	logic [7:0]  sw_addr, busy_reads, arr_data, pdata, rst_cnt, wr_data, dq_out, dq_in;
	logic [1:0]  kind;
	logic [31:0] sw_wdata, sw_rdata, e_w, m_w;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [21:0] flash_addr, wr_addr;
	logic        dq_oe, ce_n, oe_n, we_n, rb_low;
	int          failures, compares, cycles, seed, i;
	// open-drain ready pin with pull-up
	wire ready_busy_n = rb_low ? 1'b0 : 1'b1;
	flsr_host DUT (.ref_clk(ref_clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_addr(flash_addr),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .ready_busy_n(ready_busy_n));
	flsr_flash_model flash (.addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .load(load), .kind(kind), .tmo(tmo),
		.busy_reads(busy_reads), .arr_data(arr_data), .pdata(pdata), .dq_in(dq_in),
		.rb_low(rb_low), .rst_cnt(rst_cnt), .wr_addr(wr_addr), .wr_data(wr_data));
	// ****************************************
	// tasks
	// ****************************************
	task automatic end_of_test();
		if (failures == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge ref_clk);
		sw_rd <= 1'b1;
		sw_addr <= a;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge ref_clk);
		sw_rd <= 1'b0;
	endtask
	// arm the flash, start a poll, check busy, wait for the end
	task automatic run_poll(input logic [1:0] k, input logic t, input logic [7:0] n,
		input logic ce);
		int j;
		@(posedge ref_clk);
		kind <= k;
		tmo <= t;
		busy_reads <= n;
		arr_data <= 8'($random(seed)) & 8'hdf;
		pdata <= 8'($random(seed));
		load <= 1'b1;
		@(posedge ref_clk);
		load <= 1'b0;
		reg_wr(REG_CTRL, {30'h0, ce, 1'b1});
		reg_rd(REG_STAT, {28'h0, k == 2'd2, 3'h1}, 32'h9);
		for (j = 0; j < 100; j++) begin
			reg_rd(REG_STAT, 32'h0, 32'h0);
			@(negedge ref_clk);
			if (sw_rdata[STAT_BUSY] === 1'b0) break;
		end
		// poll limit run out counts as a mismatch
		if (j == 100) failures++;
	endtask
	// ****************************************
	// clock, watcher, timeout
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// marks the cycle in which read data stand
	always @(posedge ref_clk) rd_pend <= sw_rd;
	// oldest note compared against the read data
	always @(negedge ref_clk) begin
		if (rd_pend === 1'b1) begin
			e_w = exp_q.pop_front();
			m_w = msk_q.pop_front();
			if (m_w != 32'h0) cmp_val("sw_rdata", e_w & m_w, sw_rdata & m_w);
		end
	end
	// hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		reset = 1'b1;
		{sw_wr, sw_rd, load, tmo, rd_pend} = 5'h0;
		{sw_addr, sw_wdata, busy_reads, arr_data, pdata, kind} = '0;
		{failures, compares, cycles} = '0;
		seed = 99;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		cmp_val("idle pins", 32'h7, {28'h0, dq_oe, ce_n, oe_n, we_n});
		reg_rd(REG_STAT, 32'h0, 32'h7);
		reg_rd(REG_CTRL, 32'h0, 32'hffffffff);
		reg_rd(8'h0c, 32'h0, 32'hffffffff);
		reg_wr(REG_ADDR, 32'h0001_2345);
		for (i = 0; i < 4; i++) begin
			run_poll(2'd0, 1'b0, 8'(3 + ($random(seed) & 3)), i[0]);
			reg_rd(REG_STAT, {8'h0, arr_data & pdata, arr_data & pdata, 8'h0a},
				32'hffff0f);
		end
		run_poll(2'd1, 1'b0, 8'd3, 1'b1);
		reg_rd(REG_STAT, {8'h0, arr_data, arr_data, 8'h0a}, 32'hffff0f);
		reg_rd(REG_CTRL, 32'h2, 32'hffffffff);
		run_poll(2'd2, 1'b0, 8'd3, 1'b0);
		reg_rd(REG_STAT, 32'h80840a, 32'hffff0f);
		run_poll(2'd0, 1'b1, 8'd2, 1'b1);
		reg_rd(REG_STAT, {8'h0, arr_data & pdata, arr_data & pdata, 8'h0a},
			32'hffff0f);
		run_poll(2'd0, 1'b1, 8'd255, 1'b0);
		reg_rd(REG_STAT, {16'h0, ~pdata[7], 7'h60, 8'h0c}, 32'hff0f);
		@(negedge ref_clk);
		cmp_val("reset writes", 32'h1, {24'h0, rst_cnt});
		cmp_val("reset data", {24'h0, RST_CMD}, {24'h0, wr_data});
		cmp_val("reset addr", 32'h12345, {10'h0, wr_addr});
		repeat (4) @(posedge ref_clk);
		end_of_test();
	end
endmodule // flsr_host_tb_top

/* verilog/flsr_bus_cycle.sv */
/*
 * one flash bus cycle: read or write with a fixed strobe time and two
 * idle cycles after it, so every read is a separate strobe.
 * assumes the flash answers within the strobe time.
 */
module flsr_bus_cycle #(
	parameter int ADDR_W = 22
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              go,
	input  wire logic              wr,
	input  wire logic              use_ce,
	input  wire logic              hold,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic [7:0]        dq_in,
	output logic [ADDR_W-1:0]      flash_addr_r,
	output logic [7:0]             dq_out_r,
	output logic                   dq_oe_r,
	output logic                   ce_n_r,
	output logic                   oe_n_r,
	output logic                   we_n_r,
	output logic [7:0]             rdata_r,
	output logic                   busy,
	output logic                   done
);
	import flsr_pkg::*;

	logic                 busy_r;
	logic                 wr_r;
	logic [CNT_W-1:0]     cnt_r;
	wire                  strobe_nxt;
	wire                  ce_nxt;

	// ****************************************
	// strobe timing
	// ****************************************
	assign busy       = busy_r;
	assign done       = busy_r && (cnt_r == STRB_END);
	assign strobe_nxt = go || (busy_r && (cnt_r < STRB_LAST));
	// chip select pulses per access or stays low over the whole poll
	assign ce_nxt     = strobe_nxt || (!use_ce && hold);

	// cycle counter and captured data
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			busy_r  <= 1'b0;
			wr_r    <= 1'b0;
			cnt_r   <= '0;
			rdata_r <= 8'h00;
		end else if (go) begin
			busy_r <= 1'b1;
			wr_r   <= wr;
			cnt_r  <= '0;
		end else if (busy_r) begin
			cnt_r  <= cnt_r + 1'b1;
			busy_r <= !done;
			if (cnt_r == STRB_LAST && !wr_r) begin
				rdata_r <= dq_in;
			end
		end
	end

	// pins
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flash_addr_r <= '0;
			dq_out_r     <= 8'h00;
			dq_oe_r      <= 1'b0;
			ce_n_r       <= 1'b1;
			oe_n_r       <= 1'b1;
			we_n_r       <= 1'b1;
		end else begin
			if (go) begin
				flash_addr_r <= addr;
				dq_out_r     <= wdata;
			end
			dq_oe_r <= go ? wr : (busy_r && wr_r && !done);
			ce_n_r  <= !ce_nxt;
			oe_n_r  <= !(strobe_nxt && !(go ? wr : wr_r));
			we_n_r  <= !(strobe_nxt && (go ? wr : wr_r));
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_read_strobe_len: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(oe_n_r) |-> !oe_n_r[*2] ##1 oe_n_r)
		else $error("read strobe not two cycles");

endmodule // flsr_bus_cycle

/* verilog/flsr_host.sv */
/*
 * host side poller for a parallel flash: runs the toggle bit algorithm
 * on software request, writes the reset command on failure and keeps
 * status for software.
 * assumes the flash keeps its own status encodings; pins are synchronous.
 */
module flsr_host #(
	parameter int ADDR_W = 22
) (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic [7:0]        sw_addr,
	input  wire logic [31:0]       sw_wdata,
	input  wire logic              sw_wr,
	input  wire logic              sw_rd,
	output logic [31:0]            sw_rdata,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [7:0]             flash_dq_out,
	output logic                   flash_dq_oe,
	input  wire logic [7:0]        flash_dq_in,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	input  wire logic              ready_busy_n
);
	import flsr_pkg::*;

	flsr_state_t          st_r;
	flsr_state_t          st_nxt;
	logic [ADDR_W-1:0]    addr_r;
	logic                 use_ce_r;
	logic                 done_r;
	logic                 fail_r;
	logic [7:0]           first_r;
	logic [7:0]           sbyte_r;
	logic [7:0]           adata_r;
	logic [31:0]          rdata_r;
	logic                 rdy_s1_r;
	logic                 rdy_s2_r;
	logic [3:0]           rd_cnt_r;
	logic [7:0]           cyc_rdata;
	logic                 cyc_busy;
	logic                 cyc_done;
	wire                  cyc_go;
	wire                  cyc_wr;
	wire                  start;
	wire                  tog;
	wire                  tmo;
	wire [31:0]           stat_word;

	// ****************************************
	// software port decode
	// ****************************************
	assign start = sw_wr && (sw_addr == REG_CTRL) && sw_wdata[CTRL_START] && (st_r == S_IDLE);
	assign stat_word = {8'h00, adata_r, sbyte_r, 4'h0, rdy_s2_r, fail_r, done_r,
		(st_r != S_IDLE)};
	assign sw_rdata = rdata_r;

	// control registers and read data one cycle after the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			addr_r   <= '0;
			use_ce_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
		end else begin
			if (sw_wr && sw_addr == REG_CTRL && st_r == S_IDLE) begin
				use_ce_r <= sw_wdata[CTRL_USE_CE];
			end
			if (sw_wr && sw_addr == REG_ADDR && st_r == S_IDLE) begin
				addr_r <= sw_wdata[ADDR_W-1:0];
			end
			if (!sw_rd) begin
				rdata_r <= 32'h0000_0000;
			end else if (sw_addr == REG_CTRL) begin
				rdata_r <= {30'h0000_0000, use_ce_r, 1'b0};
			end else if (sw_addr == REG_ADDR) begin
				rdata_r <= 32'(addr_r);
			end else if (sw_addr == REG_STAT) begin
				rdata_r <= stat_word;
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end
	end

	// ready/busy pin synchroniser
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdy_s1_r <= 1'b0;
			rdy_s2_r <= 1'b0;
		end else begin
			rdy_s1_r <= ready_busy_n;
			rdy_s2_r <= rdy_s1_r;
		end
	end

	// ****************************************
	// toggle bit algorithm
	// ****************************************
	assign tog    = flsr_toggled(first_r, cyc_rdata);
	assign tmo    = cyc_rdata[POS_TMO];
	assign cyc_go = (st_r != S_IDLE) && !cyc_busy && !cyc_done;
	assign cyc_wr = (st_r == S_RSTW);

	// next state on start and on each finished bus cycle
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE: begin
				if (start) st_nxt = S_RD1;
			end
			S_RD1: begin
				if (cyc_done) st_nxt = S_RD2;
			end
			S_RD2: begin
				if (cyc_done && !tog) st_nxt = S_ARR;
				else if (cyc_done && tmo) st_nxt = S_RD3;
			end
			S_RD3: begin
				if (cyc_done) st_nxt = S_RD4;
			end
			S_RD4: begin
				if (cyc_done) st_nxt = tog ? S_RSTW : S_ARR;
			end
			S_ARR: begin
				if (cyc_done) st_nxt = S_IDLE;
			end
			S_RSTW: begin
				if (cyc_done) st_nxt = S_IDLE;
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	// state and poll data
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_r     <= S_IDLE;
			first_r  <= 8'h00;
			sbyte_r  <= 8'h00;
			adata_r  <= 8'h00;
			rd_cnt_r <= 4'h0;
		end else begin
			st_r <= st_nxt;
			if (start) rd_cnt_r <= 4'h0;
			else if (cyc_done && !cyc_wr && rd_cnt_r != 4'hf) rd_cnt_r <= rd_cnt_r + 4'h1;
			if (cyc_done && st_r != S_ARR && !cyc_wr) begin
				first_r <= cyc_rdata;
				sbyte_r <= cyc_rdata;
			end
			if (cyc_done && st_r == S_ARR) adata_r <= cyc_rdata;
		end
	end

	// sticky result flags, cleared on start
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			done_r <= 1'b0;
			fail_r <= 1'b0;
		end else if (start) begin
			done_r <= 1'b0;
			fail_r <= 1'b0;
		end else if (cyc_done && st_r == S_ARR) begin
			done_r <= 1'b1;
		end else if (cyc_done && st_r == S_RSTW) begin
			fail_r <= 1'b1;
		end
	end

	flsr_bus_cycle #(
		.ADDR_W(ADDR_W)
	) u_cycle (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.go           (cyc_go),
		.wr           (cyc_wr),
		.use_ce       (use_ce_r),
		.hold         (st_r != S_IDLE),
		.addr         (addr_r),
		.wdata        (RST_CMD),
		.dq_in        (flash_dq_in),
		.flash_addr_r (flash_addr),
		.dq_out_r     (flash_dq_out),
		.dq_oe_r      (flash_dq_oe),
		.ce_n_r       (flash_ce_n),
		.oe_n_r       (flash_oe_n),
		.we_n_r       (flash_we_n),
		.rdata_r      (cyc_rdata),
		.busy         (cyc_busy),
		.done         (cyc_done)
	);

	// ****************************************
	// checks
	// ****************************************
	chk_two_reads_first: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(done_r) |-> rd_cnt_r >= 4'h3)
		else $error("done without two status reads and array read");
	chk_stable_then_array: assert property (@(posedge ref_clk) disable iff (reset)
		(st_r == S_RD2 && cyc_done && !tog) |=> st_r == S_ARR ##[1:6] done_r)
		else $error("array read not taken after stable toggle");
	chk_timeout_recheck: assert property (@(posedge ref_clk) disable iff (reset)
		(st_r == S_RD2 && cyc_done && tog && tmo) |=> st_r == S_RD3)
		else $error("timeout seen without recheck");
	chk_fail_needs_reset: assert property (@(posedge ref_clk) disable iff (reset)
		$rose(fail_r) |-> $past(st_r) == S_RSTW && $past(flash_we_n, 3) == 1'b0)
		else $error("failure flagged without reset command");
	chk_reset_cmd_byte: assert property (@(posedge ref_clk) disable iff (reset)
		!flash_we_n |-> flash_dq_oe && flash_dq_out == RST_CMD)
		else $error("reset command byte wrong");
	chk_fail_after_toggle: assert property (@(posedge ref_clk) disable iff (reset)
		(st_r == S_RD4 && cyc_done && tog) |=> st_r == S_RSTW ##[1:8] fail_r)
		else $error("still toggling but no failure");
	chk_ce_per_read: assert property (@(posedge ref_clk) disable iff (reset)
		(use_ce_r && $fell(flash_oe_n)) |-> $fell(flash_ce_n))
		else $error("chip select not delimiting read");
	chk_no_write_polling: assert property (@(posedge ref_clk) disable iff (reset)
		(st_r inside {S_RD1, S_RD2, S_RD3, S_RD4}) |-> flash_we_n)
		else $error("write during status poll");

	cov_pass: cover property (@(posedge ref_clk) disable iff (reset) $rose(done_r));
	cov_fail: cover property (@(posedge ref_clk) disable iff (reset) $rose(fail_r));
	cov_tmo_ok: cover property (@(posedge ref_clk) disable iff (reset)
		st_r == S_RD4 && cyc_done && !tog);
	cov_ce_mode: cover property (@(posedge ref_clk) disable iff (reset)
		use_ce_r && $rose(done_r));

endmodule // flsr_host

/* verilog/flsr_pkg.sv */
/*
 * constants of the flash status polling host: pin timing, status byte
 * layout, register map of the software port and controller states.
 * assumes a single 20 MHz clock and a byte-wide flash data bus.
 */
//
// Overview of operation
// - after a timeout error the host writes the reset command only if toggle bit one still toggles.
// - on timeout error the host re-checks toggle bit one before failing.
// - output enable or chip select may delimit each toggle read.
// - host reads the status byte at least twice and compares toggle bit one.
// - toggling stopped means done; next read returns array data.
// - still toggling with timeout error means failure; host writes reset.
package flsr_pkg;

	// ****************************************
	// pin timing
	// ****************************************
	localparam int CLK_NS    = 50;   // ref_clk period
	localparam int T_RC_NS   = 70;   // least read or write strobe time
	localparam int STRB_CYC  = (T_RC_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W     = 3;
	localparam logic [CNT_W-1:0] STRB_LAST = CNT_W'(STRB_CYC - 1);
	localparam logic [CNT_W-1:0] STRB_END  = CNT_W'(STRB_CYC);

	// ****************************************
	// status byte fields
	// ****************************************
	localparam int POS_POLL = 7;   // data_poll_bit
	localparam int POS_TOG1 = 6;   // toggle_bit_one
	localparam int POS_TMO  = 5;   // timeout_error_bit
	localparam int POS_ETMR = 3;   // erase_timer_bit
	localparam int POS_TOG2 = 2;   // toggle_bit_two

	// ****************************************
	// software register map
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTRL_START  = 0;
	localparam int CTRL_USE_CE = 1;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_DONE   = 1;
	localparam int STAT_FAIL   = 2;
	localparam int STAT_READY  = 3;
	localparam int STAT_SBYTE  = 8;    // low bit of last status byte
	localparam int STAT_ADATA  = 16;   // low bit of array data byte
	localparam logic [7:0] RST_CMD = 8'hf0;   // flash reset command byte

	// ****************************************
	// polling states
	// ****************************************
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_RD1  = 7'h02,
		S_RD2  = 7'h04,
		S_RD3  = 7'h08,
		S_RD4  = 7'h10,
		S_ARR  = 7'h20,
		S_RSTW = 7'h40
	} flsr_state_t;

	// toggle bit one differs between two reads
	function automatic logic flsr_toggled(input logic [7:0] a, input logic [7:0] b);
		return a[POS_TOG1] ^ b[POS_TOG1];
	endfunction

endpackage
